// File: bench/link_clock_source.sv
/*
 Controller-side clock source of the port bench: both link clock pairs.
 Assumes the bench drives the command and data pins itself.
*/
`timescale 1ns/1ns
`default_nettype none

module link_clock_source
    import ddr_port_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    output clk_pair_s clk,
    output logic [2:0] ph
);
    always_ff @(negedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            ph <= 3'h0;
        else
            ph <= ph + 3'h1;
    end

    always_comb begin
        clk.k = ~ph[2];
        clk.k_n = ph[2];
        clk.c = (ph >= 3'h2) && (ph <= 3'h5);
        clk.c_n = ~clk.c;
    end
endmodule // link_clock_source

`default_nettype wire

// File: bench/tb.sv
/*
 Self-checking bench of the double-data-rate command and clock port.
 Assumes the clock source model drives both link clock pairs.
*/
`timescale 1ns/1ns
`default_nettype none

module tb
    import ddr_port_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic load_strobe_n = 1'b1;
    logic rw = 1'b0;
    logic scm = 1'b0;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [DQ_W-1:0] dq = 18'h00000;
    logic [NBYTE-1:0] bw_n = 2'h3;
    logic [2:0] ph;
    clk_pair_s ck;
    link_in_s li;
    link_out_s lo;
    int err_count = 0;
    int n_tests = 0;

    always #25 ref_clk = ~ref_clk;
    assign li = {ck, load_strobe_n, rw, addr, dq, bw_n, scm};

    link_clock_source link_clock_source_inst (.ref_clk(ref_clk), .rst_n(rst_n), .clk(ck),
        .ph(ph));
    ddr_sram_clock_command_port ddr_sram_clock_command_port_inst (.ref_clk(ref_clk),
        .rst_n(rst_n), .link_in(li), .link_out(lo));

    task automatic end_sim();
        if (err_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick();
        @(negedge ref_clk);
        #1;
    endtask

    task automatic at(input logic [2:0] p);
        do tick(); while (ph !== p);
    endtask

    task automatic echo(input logic [2:0] p_hi, input logic [2:0] p_lo);
        at(p_hi);
        chk({lo.echo_clock, lo.echo_clock_n}, 2'h2);
        at(p_lo);
        chk({lo.echo_clock, lo.echo_clock_n}, 2'h1);
    endtask

    task automatic wr(input logic [3:0] a, input logic [17:0] w0, input logic [17:0] w1,
        input logic [1:0] b0, input logic [1:0] b1);
        at(3'h7);
        {load_strobe_n, rw, addr, dq, bw_n} = {1'b0, 1'b0, a, w0, b0};
        at(3'h3);
        {load_strobe_n, rw, addr} = {1'b1, 1'b1, ~a};
        at(3'h7);
        {dq, bw_n} = {w1, b1};
        at(3'h3);
        {dq, bw_n} = {~w1, ~b1};
    endtask

    task automatic rd(input logic [3:0] a, input logic [17:0] e0, input logic [17:0] e1);
        int i;
        at(3'h7);
        {load_strobe_n, rw, addr} = {1'b0, 1'b1, a};
        at(3'h3);
        {load_strobe_n, rw, addr} = {1'b1, 1'b0, ~a};
        chk(lo.dq_oe, 1'b0);
        for (i = 0; i < 40 && lo.dq_oe !== 1'b1; i++) tick();
        chk(ph[2:1], scm ? 2'h2 : 2'h3);
        chk(lo.dq_out, e0);
        for (i = 0; i < 8 && lo.dq_out === e0; i++) tick();
        chk({lo.dq_oe, lo.dq_out}, {1'b1, e1});
        for (i = 0; i < 8 && lo.dq_oe === 1'b1; i++) tick();
        chk(lo.dq_oe, 1'b0);
    endtask

    task automatic t_bursts();
        wr(4'h5, 18'h12345, 18'h2BCDE, 2'h0, 2'h0);
        wr(4'h6, 18'h3C3C3, 18'h0F0F0, 2'h0, 2'h0);
        rd(4'h5, 18'h12345, 18'h2BCDE);
        rd(4'h6, 18'h3C3C3, 18'h0F0F0);
    endtask

    task automatic t_byte_lanes();
        wr(4'h5, 18'h3FFFF, 18'h00000, 2'h1, 2'h2);
        rd(4'h5, {9'h1FF, 9'h145}, {9'h15E, 9'h000});
    endtask

    task automatic t_single_mode();
        scm = 1'b1;
        repeat (16) tick();
        echo(3'h6, 3'h2);
        wr(4'h9, 18'h2AAAA, 18'h15555, 2'h0, 2'h0);
        rd(4'h9, 18'h2AAAA, 18'h15555);
    endtask

    task automatic t_reset();
        rst_n = 1'b0;
        tick();
        chk({lo.dq_oe, lo.echo_clock, lo.echo_clock_n}, 3'h0);
        @(negedge ref_clk);
        rst_n <= 1'b1;
        repeat (16) tick();
        echo(3'h6, 3'h2);
    endtask

    initial begin
        repeat (16) @(negedge ref_clk);
        rst_n <= 1'b1;
        echo(3'h7, 3'h3);
        t_bursts();
        t_byte_lanes();
        t_single_mode();
        t_reset();
        end_sim();
    end

    initial begin
        #200000;
        err_count++;
        end_sim();
    end
endmodule // tb

`default_nettype wire

// File: logic/ddr_port_pkg.sv
/*
 Shared widths, reset values and pin bundles of the double-data-rate
 command and clock port. Assumes one 20 MHz ref_clk samples every pin.
*/
`default_nettype none

package ddr_port_pkg;
    localparam int DQ_W = 18;
    localparam int BYTE_W = 9;
    localparam int NBYTE = 2;
    localparam int ADDR_W = 4;
    localparam int BURST_LEN = 2;
    localparam real REF_PERIOD_NS = 50.0;
    localparam logic ECHO_RST = 1'b0;

    typedef enum logic [1:0] {W_IDLE, W_WORD0, W_WORD1} wr_e;
    typedef enum logic [1:0] {R_IDLE, R_PEND, R_WORD0, R_WORD1} rd_e;

    typedef struct packed {
        logic k;
        logic k_n;
        logic c;
        logic c_n;
    } clk_pair_s;

    typedef struct packed {
        clk_pair_s clk;
        logic load_strobe_n;
        logic read_write_select;
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0] dq_in;
        logic [NBYTE-1:0] byte_write_select_n;
        logic single_clock_mode;
    } link_in_s;

    typedef struct packed {
        logic [DQ_W-1:0] dq_out;
        logic dq_oe;
        logic echo_clock;
        logic echo_clock_n;
    } link_out_s;
endpackage : ddr_port_pkg

`default_nettype wire

// File: logic/ddr_sram_clock_command_port.sv
/*
 Command, write capture, read drive and echo clocks of a two-word-burst
 double-data-rate SRAM port, with a small storage array behind it.
 Assumes all pins are asynchronous to ref_clk and that the link clocks
 run slowly enough (period of many ref_clk cycles) to be edge-detected.
*/
//
// Behaviour
// - Read_write_select high reads, low writes
// - Output clock pair times read data
// - Inputs captured on positive input clock rise
// - Accesses start on positive input clock rise
// - Write data also captured on negative clock
// - Single clock mode drives data from input pair
// - Echo clocks free-run from output clock pair
// - Single clock mode echoes the input pair
// - Load strobe low defines two-word burst
// - Data pins released when no read active
// - Deselected byte leaves stored byte unchanged
`timescale 1ns/1ns
`default_nettype none

module ddr_sram_clock_command_port
    import ddr_port_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire link_in_s link_in,
    output link_out_s link_out
);

    typedef struct packed {
        link_in_s s1;
        link_in_s s2;
        link_in_s s3;
        clk_pair_s lvl;
        logic [ADDR_W-1:0] wr_addr;
        logic [ADDR_W-1:0] rd_addr;
        wr_e wr;
        rd_e rd;
        logic [(1<<ADDR_W)-1:0][BURST_LEN-1:0][DQ_W-1:0] mem;
        link_out_s outp;
    } state_s;

    state_s st_ff;
    state_s nxt_st;
    logic k_r, kn_r, c_r, cn_r;
    logic mode, data_pos, data_neg;
    logic rd_cmd, wr_cmd;

    function automatic logic rise(input logic a2, input logic a3, input logic lvl);
        return a2 & a3 & ~lvl;
    endfunction

    function automatic logic settle(input logic a2, input logic a3, input logic lvl);
        return (a2 == a3) ? a3 : lvl;
    endfunction

    function automatic logic [DQ_W-1:0] merge_bytes(input logic [DQ_W-1:0] old_w,
                                                     input logic [DQ_W-1:0] new_w,
                                                     input logic [NBYTE-1:0] bw_n);
        logic [DQ_W-1:0] r;
        r = old_w;
        for (int i = 0; i < NBYTE; i++) begin
            if (!bw_n[i]) begin
                r[i*BYTE_W +: BYTE_W] = new_w[i*BYTE_W +: BYTE_W];
            end
        end
        return r;
    endfunction

    // Edge finding on the sampled link clocks
    always_comb begin
        k_r = rise(st_ff.s2.clk.k, st_ff.s3.clk.k, st_ff.lvl.k);
        kn_r = rise(st_ff.s2.clk.k_n, st_ff.s3.clk.k_n, st_ff.lvl.k_n);
        c_r = rise(st_ff.s2.clk.c, st_ff.s3.clk.c, st_ff.lvl.c);
        cn_r = rise(st_ff.s2.clk.c_n, st_ff.s3.clk.c_n, st_ff.lvl.c_n);
        mode = st_ff.s3.single_clock_mode;
        data_pos = mode ? k_r : c_r;
        data_neg = mode ? kn_r : cn_r;
        rd_cmd = k_r & ~st_ff.s3.load_strobe_n & st_ff.s3.read_write_select;
        wr_cmd = k_r & ~st_ff.s3.load_strobe_n & ~st_ff.s3.read_write_select;
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = link_in;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.lvl.k = settle(st_ff.s2.clk.k, st_ff.s3.clk.k, st_ff.lvl.k);
        nxt_st.lvl.k_n = settle(st_ff.s2.clk.k_n, st_ff.s3.clk.k_n, st_ff.lvl.k_n);
        nxt_st.lvl.c = settle(st_ff.s2.clk.c, st_ff.s3.clk.c, st_ff.lvl.c);
        nxt_st.lvl.c_n = settle(st_ff.s2.clk.c_n, st_ff.s3.clk.c_n, st_ff.lvl.c_n);

        if (kn_r && st_ff.wr == W_WORD0) begin
            nxt_st.mem[st_ff.wr_addr][0] = merge_bytes(st_ff.mem[st_ff.wr_addr][0],
                st_ff.s3.dq_in, st_ff.s3.byte_write_select_n);
            nxt_st.wr = W_WORD1;
        end
        if (k_r && st_ff.wr == W_WORD1) begin
            nxt_st.mem[st_ff.wr_addr][1] = merge_bytes(st_ff.mem[st_ff.wr_addr][1],
                st_ff.s3.dq_in, st_ff.s3.byte_write_select_n);
            nxt_st.wr = W_IDLE;
        end

        case (st_ff.rd)
            R_PEND: begin
                if (data_pos) begin
                    nxt_st.outp.dq_out = st_ff.mem[st_ff.rd_addr][0];
                    nxt_st.outp.dq_oe = 1'b1;
                    nxt_st.rd = R_WORD0;
                end
            end
            R_WORD0: begin
                if (data_neg) begin
                    nxt_st.outp.dq_out = st_ff.mem[st_ff.rd_addr][1];
                    nxt_st.rd = R_WORD1;
                end
            end
            R_WORD1: begin
                if (data_pos) begin
                    nxt_st.outp.dq_oe = 1'b0;
                    nxt_st.rd = R_IDLE;
                end
            end
            default: begin
                nxt_st.outp.dq_oe = 1'b0;
            end
        endcase

        if (rd_cmd) begin
            nxt_st.rd_addr = st_ff.s3.addr;
            nxt_st.rd = R_PEND;
        end
        if (wr_cmd) begin
            nxt_st.wr_addr = st_ff.s3.addr;
            nxt_st.wr = W_WORD0;
        end

        nxt_st.outp.echo_clock = mode ? nxt_st.lvl.k : nxt_st.lvl.c;
        nxt_st.outp.echo_clock_n = mode ? nxt_st.lvl.k_n : nxt_st.lvl.c_n;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign link_out = st_ff.outp;

    // Assertion helpers
    logic [BYTE_W-1:0] wr_low_byte;
    logic [DQ_W-1:0] rd_word0;
    assign wr_low_byte = st_ff.mem[st_ff.wr_addr][0][BYTE_W-1:0];
    assign rd_word0 = st_ff.mem[st_ff.rd_addr][0];

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_rd_load;
        rd_cmd;
    endsequence
    sequence s_rd_first;
        st_ff.rd == R_PEND && data_pos;
    endsequence

    property p_rd_load;
        s_rd_load |=> st_ff.rd == R_PEND && st_ff.rd_addr == $past(st_ff.s3.addr);
    endproperty
    a_rd_load: assert property (p_rd_load) else $error("read load not taken");

    property p_wr_load;
        wr_cmd |=> st_ff.wr == W_WORD0 && st_ff.wr_addr == $past(st_ff.s3.addr);
    endproperty
    a_wr_load: assert property (p_wr_load) else $error("write load not taken");

    property p_cap_k;
        !k_r |=> $stable(st_ff.rd_addr) && $stable(st_ff.wr_addr);
    endproperty
    a_cap_k: assert property (p_cap_k) else $error("address taken off K rise");

    property p_wr_word0;
        kn_r && st_ff.wr == W_WORD0 && st_ff.s3.byte_write_select_n == '0
            |=> st_ff.mem[st_ff.wr_addr][0] == $past(st_ff.s3.dq_in) && st_ff.wr == W_WORD1;
    endproperty
    a_wr_word0: assert property (p_wr_word0) else $error("negative edge write lost");

    property p_bws;
        kn_r && st_ff.wr == W_WORD0 && st_ff.s3.byte_write_select_n[0]
            |=> wr_low_byte == $past(wr_low_byte);
    endproperty
    a_bws: assert property (p_bws) else $error("deselected byte altered");

    property p_rd_drive;
        s_rd_load ##[1:300] s_rd_first |=> st_ff.outp.dq_oe && st_ff.outp.dq_out == $past(rd_word0);
    endproperty
    a_rd_drive: assert property (p_rd_drive) else $error("first read word wrong");

    property p_hold_norm;
        !mode && !c_r && !cn_r |=> $stable(st_ff.outp.dq_out);
    endproperty
    a_hold_norm: assert property (p_hold_norm) else $error("data moved off output clock");

    property p_hold_single;
        mode && !k_r && !kn_r |=> $stable(st_ff.outp.dq_out);
    endproperty
    a_hold_single: assert property (p_hold_single) else $error("data moved off input clock");

    property p_tristate;
        st_ff.rd == R_IDLE |-> !st_ff.outp.dq_oe;
    endproperty
    a_tristate: assert property (p_tristate) else $error("driving with no read");

    property p_echo;
        !mode && c_r |=> st_ff.outp.echo_clock ##1 st_ff.outp.echo_clock;
    endproperty
    a_echo: assert property (p_echo) else $error("echo not following C");

    property p_echo_single;
        mode && kn_r |=> st_ff.outp.echo_clock_n;
    endproperty
    a_echo_single: assert property (p_echo_single) else $error("echo not following K_n");

endmodule // ddr_sram_clock_command_port

`default_nettype wire
